// File: verilog/rsl_pkg.sv
// Purpose: Shared constants for the reset strap latch
// Assumes: 25 strap pins on the peripheral address bus, 32-bit register port
// Notes: Byte offsets, strap pin positions, field positions and reset values
package rsl_pkg;
    localparam int ADDR_PINS = 25;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;

    // Register byte offsets
    localparam logic [7:0] REG_STRAP_RAW = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_FAULT = 8'h08;
    localparam logic [7:0] REG_CORE_CTRL = 8'h0c;

    // Strap positions on the address pins
    localparam int PIN_BOOT_WIDTH = 0;
    localparam int PIN_CFG_CYCLE = 1;
    localparam int PIN_CORE0_HOLD = 2;
    localparam int PIN_CORE1_HOLD = 3;
    localparam int PIN_ARBITER = 6;
    localparam int PIN_DEVCFG_LO = 7;
    localparam int PIN_DEVCFG_HI = 9;
    localparam int PIN_HOST_PORT = 10;
    localparam int PIN_PCIX_ENDPOINT_SEL_N = 11;
    localparam int PIN_PCIE_ROOTCOMPLEX_SEL_N = 12;
    localparam int PIN_CTRL_ONLY = 23;

    // Undriven straps resolve high
    localparam logic [24:0] STRAP_RESET = 25'h1ffffff;

    // Device configuration select codes
    localparam logic [2:0] DEVCFG_SINGLE_8P = 3'h0;
    localparam logic [2:0] DEVCFG_DUAL_8P = 3'h4;

    // Config register fields
    localparam int CFG_BOOT16 = 0;
    localparam int CFG_RETRY = 1;
    localparam int CFG_CORE0_HOLD = 2;
    localparam int CFG_CORE1_HOLD = 3;
    localparam int CFG_HOST_PCIE = 4;
    localparam int CFG_CTRL_ONLY = 5;
    localparam int CFG_DEVCFG_LO = 6;
    localparam int CFG_DEVCFG_HI = 8;
    localparam int CFG_VALID = 9;

    // Fault register fields
    localparam int FLT_ARBITER = 0;
    localparam int FLT_RAID = 1;
    localparam int FLT_PCIX_CR = 2;
    localparam int FLT_PCIE_ROOTCOMPLEX_SEL_N = 3;
    localparam int FLT_DEVCFG = 4;
    localparam int FLT_W = 5;

    // Core control fields
    localparam int CTL_REL0 = 0;
    localparam int CTL_REL1 = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;
endpackage : rsl_pkg

// File: verilog/rsl_strap_capture.sv
// Purpose: Catches the strap pins once, on the first clock after reset release
// Assumes: srst_i synchronous active high; pins already resolved at the wire
// Notes: Value is frozen until the next reset
`timescale 1ns/10ps
module rsl_strap_capture (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [24:0] pins_i,
    output logic [24:0] straps_o,
    output logic valid_o
);
    logic rst_seen;

    // Remember reset so the release edge can be found
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rst_seen <= 1'b1;
        end else begin
            rst_seen <= 1'b0;
        end
    end

    // Clocked catch at release; reset only loads constants
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            straps_o <= rsl_pkg::STRAP_RESET;
            valid_o <= 1'b0;
        end else if (rst_seen) begin
            straps_o <= pins_i;
            valid_o <= 1'b1;
        end
    end
endmodule : rsl_strap_capture

// File: verilog/rsl_strap_latch.sv
// Purpose: Reset strap latch with decoded configuration and register port
// Assumes: Single 100 MHz clock, synchronous active-high reset, pins resolved by board
// Notes: Settings frozen between resets; pins handed to the peripheral bus after capture
// Function
// - Capture every address strap when primary reset is released.
// - Undriven strap reads 1, selecting the default; only pull-down gives 0.
// - Address bit 0: 0 gives 8-bit boot bus, 1 gives 16-bit.
// - Address bit 1: 0 accepts configuration cycles, 1 answers with retry.
// - Core 0 hold strap, taken on address bit 2: 0 holds core in reset.
// - Address bit 3: 0 holds core 1 in reset, 1 lets it run.
// - Host port choice on bit 10: 0 makes PCI-X function 0, 1 PCI Express.
// - Address bit 23 low selects controller-only; high setting is unsupported.
// - Config select from bits 9:7; 000 single-core, 100 dual-core, 8 ports.
// - Bit 11 pulled low by board; PCI-X works only as endpoint.
// - Bit 12 stays high; PCI Express works only as endpoint.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module rsl_strap_latch (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [24:0] periph_addr_i,
    output logic [24:0] periph_addr_o,
    output logic periph_addr_oe_o,
    input wire logic [24:0] bus_addr_i,
    input wire logic bus_addr_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic straps_valid_o,
    output logic boot_bus_16bit_o,
    output logic cfg_retry_o,
    output logic core0_hold_o,
    output logic core1_hold_o,
    output logic host_fn0_pcie_o,
    output logic controller_only_o,
    output logic [2:0] device_config_select_o,
    output logic dual_core_o,
    output logic pcix_endpoint_only_o,
    output logic pcie_endpoint_only_o,
    output logic strap_fault_o
);
    logic [24:0] strap_raw;
    logic strap_valid;
    logic [1:0] core_release;
    logic [rsl_pkg::FLT_W-1:0] fault;
    logic [31:0] config_word;
    logic core0_hold_n;
    logic core1_hold_n;
    logic outside_arbiter_sel_n;
    logic host_port_choice_n;
    logic [2:0] device_config_select;
    logic pcix_endpoint_sel_n;
    logic pcie_rootcomplex_sel_n;

    // Pin catch lives in its own module so the freeze is obvious
    rsl_strap_capture rsl_strap_capture_i (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .pins_i(periph_addr_i),
        .straps_o(strap_raw),
        .valid_o(strap_valid)
    );

    // Named views of the frozen strap vector
    assign core0_hold_n = strap_raw[rsl_pkg::PIN_CORE0_HOLD];
    assign core1_hold_n = strap_raw[rsl_pkg::PIN_CORE1_HOLD];
    assign outside_arbiter_sel_n = strap_raw[rsl_pkg::PIN_ARBITER];
    assign host_port_choice_n = strap_raw[rsl_pkg::PIN_HOST_PORT];
    assign device_config_select = strap_raw[rsl_pkg::PIN_DEVCFG_HI:rsl_pkg::PIN_DEVCFG_LO];
    assign pcix_endpoint_sel_n = strap_raw[rsl_pkg::PIN_PCIX_ENDPOINT_SEL_N];
    assign pcie_rootcomplex_sel_n = strap_raw[rsl_pkg::PIN_PCIE_ROOTCOMPLEX_SEL_N];

    // Unsupported board settings; device still runs in its only legal mode
    always_comb begin
        fault = '0;
        fault[rsl_pkg::FLT_ARBITER] = outside_arbiter_sel_n;
        fault[rsl_pkg::FLT_RAID] = strap_raw[rsl_pkg::PIN_CTRL_ONLY];
        fault[rsl_pkg::FLT_PCIX_CR] = pcix_endpoint_sel_n;
        fault[rsl_pkg::FLT_PCIE_ROOTCOMPLEX_SEL_N] = ~pcie_rootcomplex_sel_n;
        fault[rsl_pkg::FLT_DEVCFG] = (device_config_select != rsl_pkg::DEVCFG_SINGLE_8P)
            && (device_config_select != rsl_pkg::DEVCFG_DUAL_8P);
    end

    // Decoded settings, registered so every output leaves a flop
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            straps_valid_o <= 1'b0;
            boot_bus_16bit_o <= 1'b1;
            cfg_retry_o <= 1'b1;
            host_fn0_pcie_o <= 1'b1;
            controller_only_o <= 1'b1;
            device_config_select_o <= rsl_pkg::DEVCFG_SINGLE_8P;
            dual_core_o <= 1'b0;
            pcix_endpoint_only_o <= 1'b1;
            pcie_endpoint_only_o <= 1'b1;
            strap_fault_o <= 1'b0;
        end else begin
            straps_valid_o <= strap_valid;
            boot_bus_16bit_o <= strap_raw[rsl_pkg::PIN_BOOT_WIDTH];
            cfg_retry_o <= strap_raw[rsl_pkg::PIN_CFG_CYCLE];
            host_fn0_pcie_o <= host_port_choice_n;
            controller_only_o <= 1'b1; // RAID mode has no logic here
            device_config_select_o <= device_config_select;
            dual_core_o <= (device_config_select == rsl_pkg::DEVCFG_DUAL_8P);
            pcix_endpoint_only_o <= 1'b1; // No central resource mode
            pcie_endpoint_only_o <= 1'b1; // No root complex mode
            strap_fault_o <= strap_valid && (|fault);
        end
    end

    // Cores held through reset and while their strap says so
    // Software release lets firmware start a held core later
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            core0_hold_o <= 1'b1;
            core1_hold_o <= 1'b1;
        end else begin
            core0_hold_o <= ~strap_valid || (~core0_hold_n && ~core_release[rsl_pkg::CTL_REL0]);
            core1_hold_o <= ~strap_valid || (~core1_hold_n && ~core_release[rsl_pkg::CTL_REL1]);
        end
    end

    // Pins stay undriven until the catch is done, then belong to the bus
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            periph_addr_oe_o <= 1'b0;
            periph_addr_o <= '0;
        end else begin
            periph_addr_oe_o <= strap_valid && bus_addr_en_i;
            periph_addr_o <= bus_addr_i;
        end
    end

    // Core release control, the only writable register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            core_release <= rsl_pkg::CTL_RESET;
        end else if (reg_wr_i && (reg_addr_i == rsl_pkg::REG_CORE_CTRL)) begin
            core_release <= reg_wdata_i[rsl_pkg::CTL_REL1:rsl_pkg::CTL_REL0];
        end
    end

    // Config word for readback
    always_comb begin
        config_word = '0;
        config_word[rsl_pkg::CFG_BOOT16] = boot_bus_16bit_o;
        config_word[rsl_pkg::CFG_RETRY] = cfg_retry_o;
        config_word[rsl_pkg::CFG_CORE0_HOLD] = core0_hold_o;
        config_word[rsl_pkg::CFG_CORE1_HOLD] = core1_hold_o;
        config_word[rsl_pkg::CFG_HOST_PCIE] = host_fn0_pcie_o;
        config_word[rsl_pkg::CFG_CTRL_ONLY] = controller_only_o;
        config_word[rsl_pkg::CFG_DEVCFG_HI:rsl_pkg::CFG_DEVCFG_LO] = device_config_select_o;
        config_word[rsl_pkg::CFG_VALID] = straps_valid_o;
    end

    // Read data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                rsl_pkg::REG_STRAP_RAW: reg_rdata_o <= {7'h00, strap_raw};
                rsl_pkg::REG_CONFIG: reg_rdata_o <= config_word;
                rsl_pkg::REG_FAULT: reg_rdata_o <= {27'h0000000, fault};
                rsl_pkg::REG_CORE_CTRL: reg_rdata_o <= {30'h00000000, core_release};
                default: reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    // Catch equals the pins seen on the first edge after release
    capture_value_a: assert property ($rose(strap_valid) |-> strap_raw == $past(periph_addr_i))
        else $error("Captured straps differ from pins at release");

    // Straps frozen once valid
    strap_frozen_a: assert property (strap_valid && $past(strap_valid) |-> $stable(strap_raw))
        else $error("Captured straps changed after capture");

    // Boot width follows bit 0
    boot_width_a: assert property (strap_valid |=> boot_bus_16bit_o == $past(strap_raw[0]))
        else $error("Boot width does not follow strap");

    // Retry follows bit 1
    cfg_retry_a: assert property (strap_valid |=> cfg_retry_o == $past(strap_raw[1]))
        else $error("Config retry does not follow strap");

    // Core 0 held while strap low and not released
    core0_hold_a: assert property (strap_valid && !strap_raw[2] && !core_release[0] |=> core0_hold_o)
        else $error("Core 0 not held");

    // Core 1 runs when strap high
    core1_run_a: assert property (strap_valid && strap_raw[3] |=> !core1_hold_o)
        else $error("Core 1 held although strap high");

    // Host function 0 choice follows bit 10
    host_choice_a: assert property (strap_valid |=> host_fn0_pcie_o == $past(strap_raw[10]))
        else $error("Host port choice wrong");

    // Dual core only for code 100
    dual_core_a: assert property (strap_valid && strap_raw[9:7] == 3'h4 |=> dual_core_o && device_config_select_o == 3'h4)
        else $error("Dual core select wrong");

    // No pin drive before capture
    pin_release_a: assert property (periph_addr_oe_o |-> $past(strap_valid))
        else $error("Address pins driven before capture");

    // Endpoint-only and controller-only always once valid
    endpoint_only_a: assert property (straps_valid_o |-> pcix_endpoint_only_o && pcie_endpoint_only_o && controller_only_o)
        else $error("Unsupported mode selected");

    // Undriven-high default seen right after reset
    default_high_a: assert property ($fell(srst_i) |-> strap_raw == rsl_pkg::STRAP_RESET && !strap_valid)
        else $error("Straps not at default during capture wait");

    // Core 0 runs once its strap is captured high
    core0_run_a: assert property (strap_valid && core0_hold_n |=> !core0_hold_o)
        else $error("Core 0 held although strap high");

    // Both cores stay held until the catch is done
    hold_early_a: assert property (!strap_valid |=> core0_hold_o && core1_hold_o)
        else $error("Core released before capture");

    // Core 1 held while strap low and not released
    core1_hold_a: assert property (strap_valid && !core1_hold_n && !core_release[1] |=> core1_hold_o)
        else $error("Core 1 not held");

    // Valid output trails the internal flag by one flop
    valid_out_a: assert property (strap_valid |=> straps_valid_o)
        else $error("Valid output missing after capture");

    // Once caught, only reset clears the flag
    valid_keep_a: assert property (strap_valid |=> strap_valid)
        else $error("Capture flag dropped without reset");

    // Arbiter strap left high is a board fault
    arbiter_fault_a: assert property (strap_valid && outside_arbiter_sel_n |=> strap_fault_o)
        else $error("Arbiter strap fault not flagged");

    // RAID setting flagged, controller-only kept
    raid_fault_a: assert property (strap_valid && strap_raw[rsl_pkg::PIN_CTRL_ONLY]
        |=> strap_fault_o && controller_only_o)
        else $error("RAID strap fault not flagged");

    // Central resource setting flagged, endpoint kept
    pcix_fault_a: assert property (strap_valid && pcix_endpoint_sel_n
        |=> strap_fault_o && pcix_endpoint_only_o)
        else $error("PCI-X endpoint strap fault not flagged");

    // Root complex setting flagged, endpoint kept
    rootcomplex_fault_a: assert property (strap_valid && !pcie_rootcomplex_sel_n
        |=> strap_fault_o && pcie_endpoint_only_o)
        else $error("Root complex strap fault not flagged");

    // Select output copies the three strap bits
    devcfg_follow_a: assert property (strap_valid |=> device_config_select_o == $past(device_config_select))
        else $error("Config select does not follow straps");

    // Single-core code never reports dual core
    single_core_a: assert property (strap_valid && device_config_select == rsl_pkg::DEVCFG_SINGLE_8P
        |=> !dual_core_o)
        else $error("Dual core set for single-core code");

    // A clean board raises no fault
    clean_board_a: assert property (strap_valid && fault == '0 |=> !strap_fault_o)
        else $error("Fault flagged on a clean board");

    // Bus drive follows the request after capture
    oe_enable_a: assert property (strap_valid && bus_addr_en_i |=> periph_addr_oe_o)
        else $error("Address pins not driven on request");

    // No request, no drive
    oe_drop_a: assert property (!bus_addr_en_i |=> !periph_addr_oe_o)
        else $error("Address pins driven without request");

    // Pin value is the bus address one cycle late
    addr_follow_a: assert property (strap_valid |=> periph_addr_o == $past(bus_addr_i))
        else $error("Pin address does not follow bus");

    // Raw readback shows the frozen capture
    raw_read_a: assert property (reg_rd_i && reg_addr_i == rsl_pkg::REG_STRAP_RAW
        |=> reg_rdata_o == {7'h00, $past(strap_raw)})
        else $error("Raw strap readback wrong");

    // Config readback mirrors the output flops
    cfg_read_a: assert property (reg_rd_i && reg_addr_i == rsl_pkg::REG_CONFIG
        |=> reg_rdata_o == $past(config_word))
        else $error("Config readback wrong");

    // Release register takes the written bits
    release_write_a: assert property (reg_wr_i && reg_addr_i == rsl_pkg::REG_CORE_CTRL
        |=> core_release == $past(reg_wdata_i[1:0]))
        else $error("Core release write lost");

    // Release register moves only on its own write
    release_keep_a: assert property (!(reg_wr_i && reg_addr_i == rsl_pkg::REG_CORE_CTRL)
        |=> $stable(core_release))
        else $error("Core release changed without write");

    // Waiting for the catch, every strap reads as undriven
    strap_default_a: assert property (!strap_valid |-> strap_raw == rsl_pkg::STRAP_RESET)
        else $error("Straps not at default before capture");
endmodule : rsl_strap_latch

// File: verif/rsl_board_straps.sv
// Purpose: Board side of the strap pins for the strap latch
// Assumes: Internal pull-up on every pin, bench picks the pull-downs
// Notes: Device drive wins while its enable is high
`timescale 1ns/10ps
module rsl_board_straps (
    input wire logic [24:0] pull_low_i,
    input wire logic [24:0] drv_i,
    input wire logic oe_i,
    output logic [24:0] pins_o
);
    // Released pins fall back to their resistor, never to the last driven value
    assign pins_o = oe_i ? drv_i : ~pull_low_i;
endmodule : rsl_board_straps

// File: verif/tb_rsl_strap_latch.sv
// Purpose: Self-checking bench for the reset strap latch
// Assumes: Board model resolves pins; register port read data one cycle late
// Notes: Each strap set is applied across a full reset
`timescale 1ns/10ps
module tb_rsl_strap_latch;
    logic ref_clk_i, srst_i, bus_addr_en_i, reg_wr_i, reg_rd_i, oe;
    logic [24:0] pins, bus_addr_i, pull_low, addr_o;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, rdata;
    logic valid, b16, retry, h0, h1, pcie, ctl, dual, xep, eep, fault;
    logic [2:0] dcs;
    int bad_count, comparisons;
    localparam logic [24:0] BOARD_OK = 25'h0800bc7;
    localparam logic [24:0] BOARD_DUAL = 25'h0800dc8;

    rsl_board_straps rsl_board_straps_i (.pull_low_i(pull_low), .drv_i(addr_o), .oe_i(oe), .pins_o(pins));
    rsl_strap_latch rsl_strap_latch_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .periph_addr_i(pins),
        .periph_addr_o(addr_o), .periph_addr_oe_o(oe), .bus_addr_i(bus_addr_i), .bus_addr_en_i(bus_addr_en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .straps_valid_o(valid), .boot_bus_16bit_o(b16), .cfg_retry_o(retry),
        .core0_hold_o(h0), .core1_hold_o(h1), .host_fn0_pcie_o(pcie), .controller_only_o(ctl),
        .device_config_select_o(dcs), .dual_core_o(dual), .pcix_endpoint_only_o(xep),
        .pcie_endpoint_only_o(eep), .strap_fault_o(fault));

    // Free-running 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // One-cycle strobes, data sampled in the cycle after the read strobe only
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    // Full reset with a new board, bounded wait for capture
    task automatic boot(input logic [24:0] m);
        int n;
        @(posedge ref_clk_i);
        srst_i <= 1'b1;
        pull_low <= m;
        bus_addr_en_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1 chk("oe in reset", 0, oe);
        chk("hold0 in reset", 1, h0);
        @(posedge ref_clk_i);
        srst_i <= 1'b0;
        for (n = 0; n < 8 && valid !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        if (n == 8) begin
            bad_count++;
            end_of_test();
        end
        chk("capture delay", 2, n);
    endtask : boot

    // Expected settings worked out from the pull-down mask
    task automatic check_cfg(input logic [24:0] m, input logic e0, input logic e1);
        logic [24:0] s;
        logic [31:0] d;
        logic [2:0] c;
        logic [4:0] f;
        s = ~m;
        c = s[9:7];
        f = {c != 3'h0 && c != 3'h4, ~s[12], s[11], s[23], s[6]};
        chk("boot16", s[0], b16);
        chk("retry", s[1], retry);
        chk("hold0", e0, h0);
        chk("hold1", e1, h1);
        chk("host pcie", s[10], pcie);
        chk("ctrl only", 1, ctl);
        chk("devcfg", c, dcs);
        chk("dual", c == 3'h4, dual);
        chk("endpoints", 3, {xep, eep});
        chk("fault", |f, fault);
        rd(8'h00, d);
        chk("raw", {7'h0, s}, d);
        rd(8'h04, d);
        chk("cfg word", {22'h0, 1'h1, c, 1'h1, s[10], e1, e0, s[1], s[0]}, d);
        rd(8'h08, d);
        chk("fault word", {27'h0, f}, d);
    endtask : check_cfg

    task automatic sc_defaults;
        boot(25'h0);
        check_cfg(25'h0, 1'b0, 1'b0);
    endtask : sc_defaults

    task automatic sc_board_ok;
        logic [31:0] d;
        boot(BOARD_OK);
        check_cfg(BOARD_OK, 1'b1, 1'b0);
        wr(8'h0c, 32'h1);
        wr(8'h00, 32'hffffffff);
        @(posedge ref_clk_i);
        #1 chk("hold0 released", 0, h0);
        rd(8'h00, d);
        chk("raw after write", {7'h0, ~BOARD_OK}, d);
        rd(8'h10, d);
        chk("unmapped", 0, d);
    endtask : sc_board_ok

    task automatic sc_dual;
        boot(BOARD_DUAL);
        check_cfg(BOARD_DUAL, 1'b0, 1'b1);
        wr(8'h0c, 32'h2);
        @(posedge ref_clk_i);
        #1 chk("hold1 released", 0, h1);
    endtask : sc_dual

    // Root complex strap pulled low: flagged alone, endpoint mode kept
    task automatic sc_rc_fault;
        boot(BOARD_OK | 25'h0001000);
        check_cfg(BOARD_OK | 25'h0001000, 1'b1, 1'b0);
    endtask : sc_rc_fault

    // Pins move after capture: settings must not, bus drive takes over
    task automatic sc_freeze;
        boot(BOARD_OK);
        @(posedge ref_clk_i);
        pull_low <= 25'h0;
        bus_addr_i <= 25'h1a5a5a5;
        bus_addr_en_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1 chk("oe", 1, oe);
        chk("bus addr", 25'h1a5a5a5, addr_o);
        check_cfg(BOARD_OK, 1'b1, 1'b0);
        @(posedge ref_clk_i);
        bus_addr_en_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("oe off", 0, oe);
    endtask : sc_freeze

    // All inputs set at time zero, then the scenarios in turn
    initial begin
        bad_count = 0;
        comparisons = 0;
        srst_i = 1'b1;
        bus_addr_en_i = 1'b0;
        bus_addr_i = 25'h0;
        pull_low = 25'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        sc_defaults();
        sc_board_ok();
        sc_dual();
        sc_rc_fault();
        sc_freeze();
        end_of_test();
    end
endmodule : tb_rsl_strap_latch
